// [hdl/rcfe_defines.svh]
// constants of the remote command front end
`ifndef RCFE_DEFINES_SVH
`define RCFE_DEFINES_SVH
`define RCFE_SLAVE_ADDR      8'h00
`define RCFE_BIN_ERR_HI      8'h29
`define RCFE_TEXT_LO         8'h2A
`define RCFE_LF              8'h0A
`define RCFE_CR              8'h0D
`define RCFE_TCP_PORT        16'h01F6
`define RCFE_TCP_HDR_SHORT   4'h6
`define RCFE_TCP_HDR_LONG    4'h7
`define RCFE_FULL_SCALE      16'hCCCC
`define RCFE_SET_MAX         16'hD0E5
`define RCFE_ALARM_MAX       16'hE147
`define RCFE_ALARM_MAX_LOW   16'hD2F1
`define RCFE_MIN_SLOPE_PPM   32'h0000_02D5
`define RCFE_PPM_DIV         32'h000F_4240
`define RCFE_TIMEOUT_US      32'h0000_1388
`define RCFE_CLK_MHZ         32'h0000_0019
`define RCFE_BUF_DEPTH       256
`endif

// [hdl/rcfe_mem.sv]
// telegram byte store with registered read data
`timescale 1ns/1ps
`default_nettype none
module rcfe_mem #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          i_clock,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [7:0]    i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output var  logic [7:0]    o_rdata
);
  logic [7:0] mem [DEPTH];
  always_ff @(posedge i_clock) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule : rcfe_mem
`default_nettype wire

// [hdl/rcfe_pkg.sv]
// types of the remote command front end
package rcfe_pkg;
  typedef enum logic [1:0] {RCFE_ROUTE_NONE, RCFE_ROUTE_BIN, RCFE_ROUTE_TEXT, RCFE_ROUTE_ERR} rcfe_route_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       tcp;
  } rcfe_byte_t;
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } rcfe_out_t;
  typedef struct packed {
    logic        valid;
    logic [15:0] code;
    logic        alarm;
  } rcfe_setval_t;
  typedef struct packed {
    logic        valid;
    logic [15:0] start_code;
    logic [15:0] end_code;
    logic [31:0] time_ms;
  } rcfe_seqpt_t;
endpackage : rcfe_pkg

// [hdl/rcfe_top.sv]
// remote command front end: telegram sorting, set value and slope checks
// What this block does
// - binary telegrams carry zero in the first address byte
// - first byte 1 to 41 flags a binary communication error
// - first byte 42 or above routes whole telegram to text handling
// - device is always slave at fixed address zero
// - tcp framing only on port 502, strip 7 header bytes, no text
// - tcp frames carry no checksum; body equals serial binary format
// - set values are percent codes, full scale is 0xCCCC
// - ordinary set codes accepted from 0x0000 to 0xD0E5
// - alarm thresholds accept up to 0xE147, or 0xD2F1 on some variants
// - received codes halved internally to 15 bits, lowest bit dropped
// - set values outside adjusted limits are rejected
// - returned readings use the same percent encoding
// - reject sequence point whose nonzero slope is below 0.000725 of rating per second
// - serial line settings on virtual port are ignored
// - message ends on inter-byte timeout, or on LF or CR for text
// - telegram bodies forwarded unchanged; answers and echoes are built downstream
// - register writes accepted only while remote control is active
`timescale 1ns/1ps
`default_nettype none
`include "rcfe_defines.svh"
module rcfe_top
  import rcfe_pkg::*;
#(
  parameter int          DEPTH      = `RCFE_BUF_DEPTH,
  parameter int          AW         = 8,
  parameter int unsigned TIMEOUT_CYC = `RCFE_TIMEOUT_US * `RCFE_CLK_MHZ
) (
  input  wire logic                   i_clock,
  input  wire logic                   i_rst,
  input  wire rcfe_pkg::rcfe_byte_t   i_rx,
  input  wire logic [15:0]            i_tcp_dst_port,
  input  wire logic                   i_remote_active,
  input  wire logic                   i_alarm_cap_low,
  input  wire logic [15:0]            i_limit_min,
  input  wire logic [15:0]            i_limit_max,
  input  wire rcfe_pkg::rcfe_setval_t i_setval,
  input  wire logic [15:0]            i_actual_raw,
  input  wire rcfe_pkg::rcfe_seqpt_t  i_seqpt,
  input  wire logic                   i_bin_ready,
  input  wire logic                   i_text_ready,
  output var  rcfe_pkg::rcfe_out_t    o_bin,
  output var  rcfe_pkg::rcfe_out_t    o_text,
  output var  logic                   o_bin_is_write,
  output var  logic                   o_bin_err,
  output var  logic                   o_tcp_err,
  output var  logic                   o_write_refused,
  output var  logic                   o_setval_ok,
  output var  logic                   o_setval_reject,
  output var  logic [14:0]            o_setval_dac,
  output var  logic [15:0]            o_actual_code,
  output var  logic                   o_seqpt_ok,
  output var  logic                   o_seqpt_reject
);
  import rcfe_pkg::*;

  typedef enum logic [2:0] {RCFE_S_IDLE, RCFE_S_HDR, RCFE_S_COLLECT, RCFE_S_SEND, RCFE_S_DROP} rcfe_state_t;

  // first byte decides the path; tcp frames on port 502 never go to text
  function automatic rcfe_route_t classify(input logic [7:0] b, input logic tcp);
    if (b == `RCFE_SLAVE_ADDR) classify = RCFE_ROUTE_BIN;
    else if (b <= `RCFE_BIN_ERR_HI) classify = RCFE_ROUTE_ERR;
    else if (tcp) classify = RCFE_ROUTE_ERR;
    else classify = RCFE_ROUTE_TEXT;
  endfunction : classify

  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  rcfe_state_t state, next_state;
  rcfe_route_t route, next_route;
  logic [AW-1:0] wptr, next_wptr, rptr, next_rptr;
  logic [31:0] idle_cnt, next_idle_cnt;
  logic [3:0] hdr_cnt, next_hdr_cnt;
  logic [3:0] hdr_len, next_hdr_len;
  logic is_tcp, next_is_tcp;
  logic [7:0] rdata;
  logic we;
  logic [7:0] rx_d0, rx_d1;
  logic rx_v0, rx_v1, tcp0, tcp1;
  rcfe_out_t next_bin, next_text;
  logic next_bin_err, next_tcp_err, next_write_refused, next_is_write;
  logic sending_ok, fetch_pending, next_fetch_pending;
  logic [7:0] fc, next_fc;

  // the receive strobe comes from the link side; two stages before use
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      {rx_v0, rx_v1, tcp0, tcp1} <= 4'h0;
      rx_d0 <= 8'h00;
      rx_d1 <= 8'h00;
    end else begin
      rx_v0 <= i_rx.valid;
      rx_v1 <= rx_v0;
      rx_d0 <= i_rx.data;
      rx_d1 <= rx_d0;
      tcp0  <= i_rx.tcp && (i_tcp_dst_port == `RCFE_TCP_PORT);
      tcp1  <= tcp0;
    end
  end

  // no baud, parity or framing state lives here: bytes arrive already framed
  rcfe_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem (
    .i_clock (i_clock),
    .i_we    (we),
    .i_waddr (wptr),
    .i_wdata (rx_d1),
    .i_raddr (rptr),
    .o_rdata (rdata)
  );

  assign sending_ok = (route == RCFE_ROUTE_BIN) ? i_bin_ready : i_text_ready;

  always_comb begin
    next_state = state;
    next_route = route;
    next_wptr = wptr;
    next_rptr = rptr;
    next_idle_cnt = idle_cnt;
    next_hdr_cnt = hdr_cnt;
    next_hdr_len = hdr_len;
    next_is_tcp = is_tcp;
    next_fc = fc;
    next_fetch_pending = 1'b0;
    next_bin = '0;
    next_text = '0;
    next_bin_err = 1'b0;
    next_tcp_err = 1'b0;
    next_write_refused = 1'b0;
    next_is_write = o_bin_is_write;
    we = 1'b0;
    case (state)
      RCFE_S_IDLE: begin
        next_wptr = '0;
        next_idle_cnt = '0;
        if (rx_v1) begin
          next_is_tcp = tcp1;
          if (tcp1) begin
            // header length byte count: 7 when a unit id follows the mbap header
            next_hdr_len = `RCFE_TCP_HDR_LONG;
            next_hdr_cnt = 4'h1;
            next_state = RCFE_S_HDR;
          end else begin
            next_route = classify(rx_d1, 1'b0);
            if (classify(rx_d1, 1'b0) == RCFE_ROUTE_ERR) begin
              next_bin_err = 1'b1;
              next_state = RCFE_S_DROP;
            end else begin
              we = 1'b1;
              next_wptr = AW'(1);
              next_state = RCFE_S_COLLECT;
            end
          end
        end
      end
      RCFE_S_HDR: begin
        next_idle_cnt = idle_cnt + 32'h0000_0001;
        if (rx_v1) begin
          next_idle_cnt = '0;
          // header bytes 0 to hdr_len-1 are skipped, the next byte opens the body
          if (hdr_cnt == hdr_len) begin
            next_route = classify(rx_d1, 1'b1);
            if (classify(rx_d1, 1'b1) != RCFE_ROUTE_BIN) begin
              next_tcp_err = 1'b1;
              next_state = RCFE_S_DROP;
            end else begin
              we = 1'b1;
              next_wptr = AW'(1);
              next_state = RCFE_S_COLLECT;
            end
          end
          next_hdr_cnt = hdr_cnt + 4'h1;
        end else if (idle_cnt >= TIMEOUT_CYC - 1) begin
          // a cut header is dropped once the line goes quiet
          next_state = RCFE_S_IDLE;
        end
      end
      RCFE_S_COLLECT: begin
        next_idle_cnt = idle_cnt + 32'h0000_0001;
        if (rx_v1) begin
          next_idle_cnt = '0;
          we = (wptr != '1);
          next_wptr = (wptr != '1) ? wptr + AW'(1) : wptr;
          if (wptr == AW'(1)) next_fc = rx_d1;
          if (route == RCFE_ROUTE_TEXT && (rx_d1 == `RCFE_LF || rx_d1 == `RCFE_CR)) begin
            next_rptr = '0;
            next_fetch_pending = 1'b1;
            next_state = RCFE_S_SEND;
          end
        end else if (idle_cnt >= TIMEOUT_CYC - 1) begin
          next_rptr = '0;
          next_fetch_pending = 1'b1;
          next_state = RCFE_S_SEND;
        end
      end
      RCFE_S_SEND: begin
        // binary write codes 0x05, 0x06, 0x0f, 0x10 need remote control
        if (route == RCFE_ROUTE_BIN && !i_remote_active && fc inside {8'h05, 8'h06, 8'h0F, 8'h10}) begin
          next_write_refused = 1'b1;
          next_state = RCFE_S_IDLE;
        end else if (fetch_pending) begin
          next_fetch_pending = 1'b0;
        end else if (sending_ok) begin
          // body is forwarded unchanged, echo or answer is built downstream
          if (route == RCFE_ROUTE_BIN) begin
            next_bin = '{valid: 1'b1, last: (rptr + AW'(1) == wptr), data: rdata};
            next_is_write = fc inside {8'h05, 8'h06, 8'h0F, 8'h10};
          end else begin
            next_text = '{valid: 1'b1, last: (rptr + AW'(1) == wptr), data: rdata};
          end
          next_rptr = rptr + AW'(1);
          next_fetch_pending = 1'b1;
          if (rptr + AW'(1) == wptr) next_state = RCFE_S_IDLE;
        end
      end
      RCFE_S_DROP: begin
        // swallow the rest of a bad telegram until the line goes quiet
        next_idle_cnt = rx_v1 ? '0 : idle_cnt + 32'h0000_0001;
        if (!rx_v1 && idle_cnt >= TIMEOUT_CYC - 1) next_state = RCFE_S_IDLE;
      end
      default: next_state = RCFE_S_IDLE;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state <= RCFE_S_IDLE;
      route <= RCFE_ROUTE_NONE;
      wptr <= '0;
      rptr <= '0;
      idle_cnt <= '0;
      hdr_cnt <= 4'h0;
      hdr_len <= `RCFE_TCP_HDR_SHORT;
      is_tcp <= 1'b0;
      fc <= 8'h00;
      fetch_pending <= 1'b0;
      o_bin <= '0;
      o_text <= '0;
      o_bin_err <= 1'b0;
      o_tcp_err <= 1'b0;
      o_write_refused <= 1'b0;
      o_bin_is_write <= 1'b0;
    end else begin
      state <= next_state;
      route <= next_route;
      wptr <= next_wptr;
      rptr <= next_rptr;
      idle_cnt <= next_idle_cnt;
      hdr_cnt <= next_hdr_cnt;
      hdr_len <= next_hdr_len;
      is_tcp <= next_is_tcp;
      fc <= next_fc;
      fetch_pending <= next_fetch_pending;
      o_bin <= next_bin;
      o_text <= next_text;
      o_bin_err <= next_bin_err;
      o_tcp_err <= next_tcp_err;
      o_write_refused <= next_write_refused;
      o_bin_is_write <= next_is_write;
    end
  end

  // set value and slope checks
  logic next_sv_ok, next_sv_rej, next_sp_ok, next_sp_rej, sv_nominal;
  logic [14:0] next_dac;
  logic [16:0] delta;
  logic [63:0] lhs, rhs;
  always_comb begin
    sv_nominal = i_setval.alarm
      ? (i_setval.code <= (i_alarm_cap_low ? `RCFE_ALARM_MAX_LOW : `RCFE_ALARM_MAX))
      : (i_setval.code <= `RCFE_SET_MAX);
    next_sv_ok  = i_setval.valid && sv_nominal && in_range(i_setval.code, i_limit_min, i_limit_max);
    next_sv_rej = i_setval.valid && !next_sv_ok;
    next_dac = next_sv_ok ? i_setval.code[15:1] : o_setval_dac;
    delta = (i_seqpt.end_code >= i_seqpt.start_code) ? {1'b0, i_seqpt.end_code - i_seqpt.start_code}
                                                     : {1'b0, i_seqpt.start_code - i_seqpt.end_code};
    // slope per second against 0.000725 of full scale, cross-multiplied to avoid a divider
    lhs = 64'(delta) * 64'(`RCFE_PPM_DIV) * 64'd1000;
    rhs = 64'(`RCFE_MIN_SLOPE_PPM) * 64'(`RCFE_FULL_SCALE) * 64'(i_seqpt.time_ms);
    next_sp_ok  = i_seqpt.valid && (delta == 17'h0_0000 || lhs >= rhs);
    next_sp_rej = i_seqpt.valid && !next_sp_ok;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_setval_ok <= 1'b0;
      o_setval_reject <= 1'b0;
      o_setval_dac <= 15'h0000;
      o_actual_code <= 16'h0000;
      o_seqpt_ok <= 1'b0;
      o_seqpt_reject <= 1'b0;
    end else begin
      o_setval_ok <= next_sv_ok;
      o_setval_reject <= next_sv_rej;
      o_setval_dac <= next_dac;
      o_actual_code <= i_actual_raw;
      o_seqpt_ok <= next_sp_ok;
      o_seqpt_reject <= next_sp_rej;
    end
  end
endmodule : rcfe_top
`default_nettype wire

// [verif/rcfe_chk_sva.sv]
// port assertions of the remote command front end
`timescale 1ns/1ps
`default_nettype none
module rcfe_chk
  import rcfe_pkg::*;
(
  input wire logic                   i_clock,
  input wire logic                   i_rst,
  input wire logic                   i_alarm_cap_low,
  input wire logic [15:0]            i_limit_min,
  input wire logic [15:0]            i_limit_max,
  input wire rcfe_pkg::rcfe_setval_t i_setval,
  input wire rcfe_pkg::rcfe_seqpt_t  i_seqpt,
  input wire rcfe_pkg::rcfe_out_t    o_bin,
  input wire rcfe_pkg::rcfe_out_t    o_text,
  input wire logic                   o_setval_ok,
  input wire logic                   o_setval_reject,
  input wire logic [14:0]            o_setval_dac,
  input wire logic                   o_seqpt_ok,
  input wire logic                   o_seqpt_reject
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  AST_SET_ONE: assert property (i_setval.valid |=> o_setval_ok != o_setval_reject)
    else $error("set value answer missing");
  AST_SET_IDLE: assert property (!i_setval.valid |=> !o_setval_ok && !o_setval_reject)
    else $error("set value answer without request");
  AST_SET_MAX: assert property (i_setval.valid && !i_setval.alarm && i_setval.code > 16'hD0E5 |=> o_setval_reject)
    else $error("set code above range accepted");
  AST_ALARM_MAX: assert property (i_setval.valid && i_setval.alarm &&
      i_setval.code > (i_alarm_cap_low ? 16'hD2F1 : 16'hE147) |=> o_setval_reject)
    else $error("alarm code above range accepted");
  AST_LIMIT: assert property (i_setval.valid && (i_setval.code < i_limit_min ||
      i_setval.code > i_limit_max) |=> o_setval_reject)
    else $error("set code outside limits accepted");
  AST_HALF: assert property (o_setval_ok |-> o_setval_dac == $past(i_setval.code[15:1]))
    else $error("converter code not half of request");
  AST_SEQ_ONE: assert property (i_seqpt.valid |=> o_seqpt_ok != o_seqpt_reject)
    else $error("sequence point answer missing");
  AST_SEQ_FLAT: assert property (i_seqpt.valid && i_seqpt.start_code == i_seqpt.end_code |=> o_seqpt_ok)
    else $error("flat sequence point rejected");
  AST_ROUTE: assert property (!(o_bin.valid && o_text.valid))
    else $error("byte routed to both consumers");
endmodule : rcfe_chk
bind rcfe_top rcfe_chk u_rcfe_chk (.i_clock, .i_rst, .i_alarm_cap_low, .i_limit_min, .i_limit_max,
  .i_setval, .i_seqpt, .o_bin, .o_text, .o_setval_ok, .o_setval_reject, .o_setval_dac,
  .o_seqpt_ok, .o_seqpt_reject);
`default_nettype wire

// [verif/rcfe_host.sv]
// host model: sends telegram bytes, collects forwarded bytes and flags
`timescale 1ns/1ps
`default_nettype none
module rcfe_host
  import rcfe_pkg::*;
(
  input  wire logic                 i_clock,
  input  wire rcfe_pkg::rcfe_out_t  i_bin,
  input  wire rcfe_pkg::rcfe_out_t  i_text,
  input  wire logic [2:0]           i_flag,
  output var  rcfe_pkg::rcfe_byte_t o_rx,
  output var  logic                 o_ready
);
  logic [7:0] bq[$];
  logic [7:0] tq[$];
  int         nflag;
  bit         got;
  initial o_rx = '0;
  initial o_ready = 1'b1;
  task automatic clear();
    bq.delete();
    tq.delete();
    nflag = 0;
    got = 0;
  endtask : clear
  // one idle cycle between bytes; tcp frames carry no checksum
  task automatic send(input logic [7:0] q[$], input bit tcp);
    foreach (q[i]) begin
      @(posedge i_clock);
      o_rx <= '{1'b1, q[i], tcp};
      @(posedge i_clock);
      // released data line shows the inverse, never a stale match
      o_rx <= '{1'b0, ~q[i], tcp};
    end
  endtask : send
  always @(posedge i_clock) begin
    if (i_bin.valid) bq.push_back(i_bin.data);
    if (i_text.valid) tq.push_back(i_text.data);
    if ((i_bin.valid && i_bin.last) || (i_text.valid && i_text.last) || |i_flag) got = 1;
    nflag += $countones(i_flag);
  end
endmodule : rcfe_host
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench of the remote command front end
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rcfe_pkg::*;
  typedef struct {bit sq; logic [15:0] a, b; logic [31:0] t; bit al, cap, ok;} rcfe_row_t;
  logic         clk = 0;
  logic         rst = 1;
  logic         rem = 1;
  logic         cap = 0;
  logic [15:0]  port = 16'h01F6;
  logic [15:0]  lmin = 16'h0010;
  logic [15:0]  lmax = 16'hFFFF;
  logic [15:0]  act = 16'h0000;
  wire logic [2:0] flag;
  logic         rdy, ok, rj, qok, qrj, wr;
  logic [14:0]  dac;
  logic [15:0]  acode;
  rcfe_byte_t   rx;
  rcfe_setval_t sv = '0;
  rcfe_seqpt_t  sp = '0;
  rcfe_out_t    ob, ot;
  int           fail_count = 0;
  int           total_checks = 0;
  int           k;
  // codes are 52428 times value over rating, rounded to nearest
  rcfe_row_t    rows [11] = '{'{0, 16'hD0E5, 0, 0, 0, 0, 1}, '{0, 16'hD0E6, 0, 0, 0, 0, 0},
    '{0, 16'h000F, 0, 0, 0, 0, 0}, '{0, 16'hCCCC, 0, 0, 0, 0, 1}, '{0, 16'hE147, 0, 0, 1, 0, 1},
    '{0, 16'hE148, 0, 0, 1, 0, 0}, '{0, 16'hD2F1, 0, 0, 1, 1, 1}, '{0, 16'hD2F2, 0, 0, 1, 1, 0},
    '{1, 16'h0100, 16'h0101, 32'h0000_001A, 0, 0, 1}, '{1, 16'h0101, 16'h0100, 32'h0000_001B, 0, 0, 0},
    '{1, 16'h0500, 16'h0500, 32'hFFFF_FFFF, 0, 0, 1}};
  always #20 clk = ~clk;
  // short idle timeout keeps message ends quick in simulation
  rcfe_top #(.TIMEOUT_CYC(20)) u_rcfe_top (.i_clock(clk), .i_rst(rst), .i_rx(rx), .i_tcp_dst_port(port),
    .i_remote_active(rem), .i_alarm_cap_low(cap), .i_limit_min(lmin), .i_limit_max(lmax), .i_setval(sv),
    .i_actual_raw(act), .i_seqpt(sp), .i_bin_ready(rdy), .i_text_ready(rdy), .o_bin(ob), .o_text(ot),
    .o_bin_is_write(wr), .o_bin_err(flag[0]), .o_tcp_err(flag[1]), .o_write_refused(flag[2]),
    .o_setval_ok(ok), .o_setval_reject(rj), .o_setval_dac(dac), .o_actual_code(acode),
    .o_seqpt_ok(qok), .o_seqpt_reject(qrj));
  rcfe_host u_rcfe_host (.i_clock(clk), .i_bin(ob), .i_text(ot), .i_flag(flag), .o_rx(rx), .o_ready(rdy));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic tg(input logic [7:0] q[$], input bit tcp, input int nb, input int nt, input int nf);
    u_rcfe_host.clear();
    u_rcfe_host.send(q, tcp);
    for (k = 0; k < 400 && !u_rcfe_host.got; k++) @(posedge clk);
    if (!u_rcfe_host.got) begin
      fail_count++;
      close_out();
    end
    repeat (30) @(posedge clk);
    chk(u_rcfe_host.bq.size(), nb);
    chk(u_rcfe_host.tq.size(), nt);
    chk(u_rcfe_host.nflag, nf);
    for (k = 0; k < nb; k++) chk(u_rcfe_host.bq[k], q[k + (tcp ? 7 : 0)]);
    for (k = 0; k < nt; k++) chk(u_rcfe_host.tq[k], q[k]);
    $display("telegram test done at %0t", $time);
  endtask : tg
  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    foreach (rows[i]) begin
      @(posedge clk);
      cap <= rows[i].cap;
      if (rows[i].sq) sp <= '{1'b1, rows[i].a, rows[i].b, rows[i].t};
      else sv <= '{1'b1, rows[i].a, rows[i].al};
      @(posedge clk);
      sv.valid <= 0;
      sp.valid <= 0;
      #1;
      if (rows[i].sq) chk({qok, qrj}, {rows[i].ok, !rows[i].ok});
      else chk({ok, rj}, {rows[i].ok, !rows[i].ok});
      if (!rows[i].sq && rows[i].ok) chk(dac, rows[i].a[15:1]);
    end
    $display("table test done at %0t", $time);
    // back to back requests against a lowered upper limit
    @(posedge clk);
    lmax <= 16'h8000;
    sv <= '{1'b1, 16'h8001, 1'b0};
    @(posedge clk);
    sv <= '{1'b1, 16'h8000, 1'b0};
    #1;
    chk({ok, rj}, 2'b01);
    @(posedge clk);
    sv.valid <= 0;
    #1;
    chk({ok, rj}, 2'b10);
    chk(dac, 15'h4000);
    $display("limit test done at %0t", $time);
    tg('{8'h00, 8'h03, 8'h00, 8'h05, 8'h00, 8'h01, 8'hA1, 8'hB2}, 0, 8, 0, 0);
    chk(wr, 1'b0);
    tg('{8'h2A, 8'h49, 8'h44, 8'h0A}, 0, 0, 4, 0);
    tg('{8'h4D, 8'h45, 8'h41, 8'h53}, 0, 0, 4, 0);
    tg('{8'h29, 8'h03, 8'h00}, 0, 0, 0, 1);
    tg('{8'h01, 8'h03, 8'h00}, 0, 0, 0, 1);
    tg('{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h06, 8'h00, 8'h00, 8'h03, 8'h00, 8'h05, 8'h00, 8'h01}, 1, 6, 0, 0);
    tg('{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h06, 8'h00, 8'h05, 8'h03, 8'h00, 8'h05, 8'h00, 8'h01}, 1, 0, 0, 1);
    @(posedge clk);
    port <= 16'h13A5;
    tg('{8'h4D, 8'h45, 8'h41, 8'h53}, 1, 0, 4, 0);
    @(posedge clk);
    rem <= 0;
    tg('{8'h00, 8'h06, 8'h00, 8'h10, 8'h12, 8'h34, 8'hC1, 8'hD2}, 0, 0, 0, 1);
    @(posedge clk);
    rem <= 1;
    tg('{8'h00, 8'h06, 8'h00, 8'h10, 8'h12, 8'h34, 8'hC1, 8'hD2}, 0, 8, 0, 0);
    chk(wr, 1'b1);
    // readings and reset in mid run
    @(posedge clk);
    act <= 16'hCCCC;
    repeat (3) @(posedge clk);
    #1;
    chk(acode, 16'hCCCC);
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    #1;
    chk(dac, 0);
    chk(acode, 0);
    chk({ok, qok}, 0);
    @(posedge clk);
    rst <= 0;
    repeat (2) @(posedge clk);
    #1;
    chk({ob.valid, ot.valid, flag, ok, rj, qok, qrj}, 0);
    $display("reset test done at %0t", $time);
    close_out();
  end
endmodule : testbench
`default_nettype wire
